// file: pkg/pmhi_consts.vh
// register map, field positions, reset values and link constants of the host port
`ifndef PMHI_CONSTS_VH
`define PMHI_CONSTS_VH
// bus byte offsets; the serial pointer uses offset/4
`define PMHI_OFS_GSTAT    5'h00
`define PMHI_OFS_VSTAT    5'h04
`define PMHI_OFS_GMASK    5'h08
`define PMHI_OFS_VMASK    5'h0C
`define PMHI_OFS_SERCTL   5'h10
`define PMHI_OFS_CONV2    5'h14
`define PMHI_OFS_OUTEN    5'h18
`define PMHI_OFS_EMODE    5'h1C
// register indices (offset / 4)
`define PMHI_IDX_GSTAT    3'h0
`define PMHI_IDX_VSTAT    3'h1
`define PMHI_IDX_GMASK    3'h2
`define PMHI_IDX_VMASK    3'h3
`define PMHI_IDX_SERCTL   3'h4
`define PMHI_IDX_CONV2    3'h5
`define PMHI_IDX_OUTEN    3'h6
`define PMHI_IDX_EMODE    3'h7
// general status bits
`define PMHI_G_FACTORY    0
`define PMHI_G_TEMP       1
// serial control bits
`define PMHI_S_PULLUP     0
`define PMHI_S_DIRECT     1
// second converter control bits
`define PMHI_C_OVDIS      0
`define PMHI_C_CLAMP      1
// reset values
`define PMHI_RST_GMASK    8'h01
`define PMHI_RST_VMASK    8'h00
`define PMHI_RST_SERCTL   8'h01
`define PMHI_RST_CONV2    8'h00
// energy modes
`define PMHI_EM_ACTIVE    2'h0
`define PMHI_EM_SLEEP     2'h1
`define PMHI_EM_SHUTDOWN  2'h2
// serial target address
`define PMHI_TARGET_ADDR  7'h60
// factory load time in clock cycles
`define PMHI_LOAD_CYCLES  8
`endif

// file: core/pmhi_top.v
// host port, status flags, interrupt pin and supply sequencing of the power controller
`timescale 1ns/1ps
`default_nettype none
`include "pmhi_consts.vh"

// Operation
// RL1 - serial target only, 10 kbit/s to 5 Mbit/s
// RL2 - serial port works in all energy modes
// RL3 - answer only fixed seven-bit address 0x60
// RL4 - pull-ups on at startup, software can disable
// RL5 - direct mode sets energy mode, drops pull-ups
// RL6 - interrupt pin open-drain, pull-up always on
// RL7 - interrupt when set flag is unmasked
// RL8 - pin low until unmasked flags cleared
// RL9 - reset mask: only factory-read unmasked
// RL10 - every reset reads factory memory, sets flag
// RL11 - host rewrites setup on factory-read interrupt
// RL12 - under-voltage lockout enters minimal-power state
// RL13 - load defaults first, then converters regulate
// RL14 - supply below power-on threshold: reset, outputs off
// RL15 - over-voltage load in active and sleep modes
// RL16 - control bit disables second output protection
// RL17 - clamp bit clamps second output
// RL18 - out of regulation sets per-output low flag
// RL19 - over-temperature sets temperature fault flag
// RL20 - host should unmask fault flags at startup
// RL21 - enabled output regulates at once
// RL22 - disabled outputs held high-impedance
// RL23 - flags stay until host clears them
module pmhi_top #(
  parameter NOUT       = 3,                  // number of supply outputs
  parameter OUTEN_INIT = 8'h00               // factory output enables
) (
  input  wire            clk,                // system clock
  input  wire            rst_b,              // async reset, active low
  input  wire [4:0]      avs_address,        // byte address
  input  wire            avs_read,           // read request
  input  wire            avs_write,          // write request
  input  wire [31:0]     avs_writedata,      // write data
  output reg  [31:0]     avs_readdata,       // read data
  output reg             avs_waitrequest,    // stall
  input  wire            sclIn,              // serial clock pin level
  input  wire            sdaIn,              // serial data pin level
  output reg             sdaOut,             // serial data drive value
  output reg             sdaOe_b,            // low while driving data
  output reg             serialPullup,       // pull-ups on clock and data
  output reg             irqOut,             // interrupt drive value
  output reg             irqOe_b,            // low while pulling pin low
  output reg             irqPullup,          // interrupt pin pull-up
  input  wire            supplyOk,           // main supply above power-on level
  input  wire            lockoutTrip,        // under-voltage lockout tripped
  input  wire            tempHot,            // over-temperature detector
  input  wire [NOUT-1:0] outLow,             // output out of regulation
  input  wire [NOUT-1:0] outOverVolt,        // output above level plus margin
  output reg  [NOUT-1:0] outRegulate,        // converter regulating
  output reg  [NOUT-1:0] outHiZ,             // output high-impedance
  output reg  [NOUT-1:0] ovLoad,             // small internal load on
  output reg             clampOn,            // second output clamp on
  output reg  [1:0]      energyMode,         // current energy mode
  output reg             lowPower            // minimal-power lockout state
);

  // sequencer states, one-hot
  localparam [2:0] SQ_OFF  = 3'b001;         // held in reset
  localparam [2:0] SQ_LOAD = 3'b010;         // loading defaults
  localparam [2:0] SQ_RUN  = 3'b100;         // normal operation
  // serial target states, one-hot
  localparam [4:0] SB_IDLE = 5'b00001;       // waiting for start
  localparam [4:0] SB_RX   = 5'b00010;       // shifting in a byte
  localparam [4:0] SB_ACK  = 5'b00100;       // driving acknowledge
  localparam [4:0] SB_TX   = 5'b01000;       // shifting out a byte
  localparam [4:0] SB_RACK = 5'b10000;       // host acknowledge slot
  localparam       NSYNC   = 5 + 2 * NOUT;   // async inputs synchronised

  // two-flop synchroniser for every pin input, third stage for edges
  reg  [NSYNC-1:0] syncA_q;                  // first stage, read by syncB only
  reg  [NSYNC-1:0] syncB_q;                  // usable level
  reg  [1:0]       linkOld_q;                // delayed clock and data
  wire [NSYNC-1:0] rawIn;                    // all async inputs
  assign rawIn = {outOverVolt, outLow, tempHot, lockoutTrip, supplyOk, sdaIn, sclIn};
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      syncA_q   <= {NSYNC{1'b0}};
      syncB_q   <= {NSYNC{1'b0}};
      linkOld_q <= 2'b11;
    end else begin
      syncA_q   <= rawIn;
      syncB_q   <= syncA_q;
      linkOld_q <= syncB_q[1:0];
    end
  end

  wire            scl     = syncB_q[0];      // synced serial clock
  wire            sda     = syncB_q[1];      // synced serial data
  wire            supOk   = syncB_q[2];      // synced supply good
  wire            lockout = syncB_q[3];      // synced lockout
  wire            hot     = syncB_q[4];      // synced over-temperature
  wire [NOUT-1:0] lowS    = syncB_q[5 +: NOUT];         // synced low flags
  wire [NOUT-1:0] ovS     = syncB_q[5 + NOUT +: NOUT];  // synced over-voltage
  // edges found by sampling the link clock on clk [RL1]
  wire sclRise = scl & ~linkOld_q[0];        // serial clock rising
  wire sclFall = ~scl & linkOld_q[0];        // serial clock falling
  wire startC  = scl & linkOld_q[0] & ~sda & linkOld_q[1];  // start condition
  wire stopC   = scl & linkOld_q[0] & sda & ~linkOld_q[1];  // stop condition

  // register state
  reg [2:0]      seq_q;                      // sequencer state
  reg [7:0]      loadCnt_q;                  // factory load timer
  reg [7:0]      gStat_q;                    // general status flags
  reg [NOUT-1:0] vStat_q;                    // voltage status flags
  reg [7:0]      gMask_q;                    // general_status_mask
  reg [7:0]      vMask_q;                    // voltage_status_mask
  reg [7:0]      serCtl_q;                   // pull-up and direct mode
  reg [7:0]      conv2_q;                    // second_converter_control0
  reg [7:0]      outEn_q;                    // output enables
  reg [1:0]      emode_q;                    // energy mode
  // serial target state
  reg [4:0]      sb_q;                       // target state
  reg [7:0]      shift_q;                    // shift register
  reg [3:0]      bitCnt_q;                   // bits in current byte
  reg [1:0]      byteNo_q;                   // byte in transfer, saturates at 2
  reg            rdMode_q;                   // read transfer addressed
  reg            nack_q;                     // host declined next byte
  reg [7:0]      ptr_q;                      // register pointer
  reg            sWr_q;                      // serial write pulse
  reg [7:0]      sWrIdx_q;                   // serial write index
  reg [7:0]      sWrDat_q;                   // serial write data

  wire run = seq_q == SQ_RUN;                // normal operation
  wire serctlPull   = serCtl_q[`PMHI_S_PULLUP];
  wire serctlDirect = serCtl_q[`PMHI_S_DIRECT];

  // register read view, bits above 8 read as zero
  function [7:0] regView;
    input [7:0] idx;
    begin
      case (idx)
        8'h00:   regView = gStat_q;
        8'h01:   regView = {{(8-NOUT){1'b0}}, vStat_q};
        8'h02:   regView = gMask_q;
        8'h03:   regView = vMask_q;
        8'h04:   regView = serCtl_q;
        8'h05:   regView = conv2_q;
        8'h06:   regView = outEn_q;
        8'h07:   regView = {6'h00, emode_q};
        default: regView = 8'h00;    // unmapped reads zero
      endcase
    end
  endfunction

  // bus slave: one wait cycle, action at the edge waitrequest is low
  wire       avReq  = avs_read | avs_write;  // request pending
  wire       avTake = avReq & ~avs_waitrequest;
  wire       avWr   = avs_write & avTake;    // bus write now
  // one write port; the bus wins over the serial port in a tie
  wire       wrEn   = avWr | sWr_q;
  wire [7:0] wrIdx  = avWr ? {5'h00, avs_address[4:2]} : sWrIdx_q;
  wire [7:0] wrDat  = avWr ? avs_writedata[7:0] : sWrDat_q;
  wire       wrHit  = wrEn & (wrIdx[7:3] == 5'h00);

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
    end else if (avReq & avs_waitrequest) begin
      avs_waitrequest <= 1'b0;
      avs_readdata    <= {24'h00_0000, regView({5'h00, avs_address[4:2]})};
    end else begin
      avs_waitrequest <= 1'b1;           // back to stall after each answer
    end
  end

  // supply sequencer: lockout or low supply hold reset, then load, then run
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      seq_q     <= SQ_OFF;
      loadCnt_q <= 8'h00;
    end else begin
      case (seq_q)
        SQ_OFF: begin
          loadCnt_q <= 8'h00;
          if (supOk & ~lockout)
            seq_q <= SQ_LOAD;                // defaults first [RL13]
        end
        SQ_LOAD: begin
          loadCnt_q <= loadCnt_q + 8'h01;
          if (~supOk | lockout)
            seq_q <= SQ_OFF;                 // [RL14]
          else if (loadCnt_q == `PMHI_LOAD_CYCLES - 1)
            seq_q <= SQ_RUN;                 // regulation only after load [RL13]
        end
        SQ_RUN: begin
          if (~supOk | lockout)
            seq_q <= SQ_OFF;                 // [RL12] [RL14]
        end
        default: seq_q <= SQ_OFF;
      endcase
    end
  end

  // registers: defaults reloaded while off, writes from bus or serial port
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      gStat_q  <= 8'h00;
      vStat_q  <= {NOUT{1'b0}};
      gMask_q  <= `PMHI_RST_GMASK;           // [RL9]
      vMask_q  <= `PMHI_RST_VMASK;           // [RL9]
      serCtl_q <= `PMHI_RST_SERCTL;          // pull-ups on [RL4]
      conv2_q  <= `PMHI_RST_CONV2;
      outEn_q  <= 8'h00;
      emode_q  <= `PMHI_EM_ACTIVE;
    end else if (seq_q == SQ_OFF) begin
      // reset state clears the flags, reloads reset values and keeps outputs off [RL14]
      gStat_q  <= 8'h00;
      vStat_q  <= {NOUT{1'b0}};
      gMask_q  <= `PMHI_RST_GMASK;           // [RL9]
      vMask_q  <= `PMHI_RST_VMASK;
      serCtl_q <= `PMHI_RST_SERCTL;          // [RL4]
      conv2_q  <= `PMHI_RST_CONV2;
      outEn_q  <= 8'h00;
      emode_q  <= `PMHI_EM_ACTIVE;
    end else begin
      // flags: set wins over a write-one clear [RL23]
      gStat_q[`PMHI_G_FACTORY] <= (gStat_q[`PMHI_G_FACTORY]
        & ~(wrHit & wrIdx[2:0] == `PMHI_IDX_GSTAT & wrDat[`PMHI_G_FACTORY]))
        | (seq_q == SQ_LOAD && loadCnt_q == `PMHI_LOAD_CYCLES - 1);  // [RL10]
      gStat_q[`PMHI_G_TEMP] <= (gStat_q[`PMHI_G_TEMP]
        & ~(wrHit & wrIdx[2:0] == `PMHI_IDX_GSTAT & wrDat[`PMHI_G_TEMP]))
        | hot;                               // [RL19]
      vStat_q <= (vStat_q & ~({NOUT{wrHit & wrIdx[2:0] == `PMHI_IDX_VSTAT}}
        & wrDat[NOUT-1:0])) | lowS;          // [RL18] [RL23]
      // load factory output enables at the end of the load
      if (seq_q == SQ_LOAD && loadCnt_q == `PMHI_LOAD_CYCLES - 1)
        outEn_q <= OUTEN_INIT;               // [RL13]
      else if (wrHit && wrIdx[2:0] == `PMHI_IDX_OUTEN)
        outEn_q <= wrDat;
      if (wrHit && wrIdx[2:0] == `PMHI_IDX_GMASK)
        gMask_q <= wrDat;
      if (wrHit && wrIdx[2:0] == `PMHI_IDX_VMASK)
        vMask_q <= wrDat;
      if (wrHit && wrIdx[2:0] == `PMHI_IDX_SERCTL)
        serCtl_q <= wrDat;                   // pull-up off by software [RL4]
      if (wrHit && wrIdx[2:0] == `PMHI_IDX_CONV2)
        conv2_q <= wrDat;                    // [RL16] [RL17]
      // direct mode: pin levels pick the mode, register writes ignored
      if (serctlDirect && sb_q == SB_IDLE)
        emode_q <= sda ? `PMHI_EM_ACTIVE : (scl ? `PMHI_EM_SLEEP : `PMHI_EM_SHUTDOWN);  // [RL5]
      else if (wrHit && wrIdx[2:0] == `PMHI_IDX_EMODE && wrDat[1:0] != 2'h3)
        emode_q <= wrDat[1:0];
    end
  end

  // serial target: fixed address, pointer byte, then data bytes [RL1] [RL2]
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sb_q     <= SB_IDLE;
      shift_q  <= 8'h00;
      bitCnt_q <= 4'h0;
      byteNo_q <= 2'h0;
      rdMode_q <= 1'b0;
      nack_q   <= 1'b0;
      ptr_q    <= 8'h00;
      sWr_q    <= 1'b0;
      sWrIdx_q <= 8'h00;
      sWrDat_q <= 8'h00;
      sdaOe_b  <= 1'b1;
    end else begin
      sWr_q <= 1'b0;
      if (seq_q == SQ_OFF || serctlDirect || stopC) begin
        sb_q    <= SB_IDLE;                  // direct mode borrows the pins
        sdaOe_b <= 1'b1;
      end else if (startC) begin
        sb_q     <= SB_RX;                   // start or repeated start
        bitCnt_q <= 4'h0;
        byteNo_q <= 2'h0;
        sdaOe_b  <= 1'b1;
      end else begin
        case (sb_q)
          SB_IDLE: sdaOe_b <= 1'b1;
          SB_RX: begin
            if (sclRise && bitCnt_q != 4'h8) begin
              shift_q  <= {shift_q[6:0], sda};
              bitCnt_q <= bitCnt_q + 4'h1;
            end else if (sclFall && bitCnt_q == 4'h8) begin
              if (byteNo_q == 2'h0) begin
                // only the fixed address is answered [RL3]
                if (shift_q[7:1] == `PMHI_TARGET_ADDR) begin
                  rdMode_q <= shift_q[0];
                  sb_q     <= SB_ACK;
                  sdaOe_b  <= 1'b0;
                end else begin
                  sb_q <= SB_IDLE;
                end
              end else begin
                if (byteNo_q == 2'h1) begin
                  ptr_q <= shift_q;          // pointer byte
                end else begin
                  sWr_q    <= 1'b1;          // data byte written, pointer steps
                  sWrIdx_q <= ptr_q;
                  sWrDat_q <= shift_q;
                  ptr_q    <= ptr_q + 8'h01;
                end
                sb_q    <= SB_ACK;
                sdaOe_b <= 1'b0;
              end
              if (byteNo_q != 2'h2)
                byteNo_q <= byteNo_q + 2'h1;
            end
          end
          SB_ACK: begin
            if (sclFall) begin
              bitCnt_q <= 4'h0;
              if (rdMode_q) begin
                shift_q <= regView(ptr_q);   // first read byte
                ptr_q   <= ptr_q + 8'h01;
                sdaOe_b <= regView(ptr_q) >> 7 == 8'h01;
                sb_q    <= SB_TX;
              end else begin
                sdaOe_b <= 1'b1;
                sb_q    <= SB_RX;
              end
            end
          end
          SB_TX: begin
            if (sclFall) begin
              if (bitCnt_q == 4'h7) begin
                sdaOe_b <= 1'b1;             // release for host acknowledge
                sb_q    <= SB_RACK;
              end else begin
                shift_q  <= {shift_q[6:0], 1'b0};
                sdaOe_b  <= shift_q[6];      // drive low for a zero bit
                bitCnt_q <= bitCnt_q + 4'h1;
              end
            end
          end
          SB_RACK: begin
            if (sclRise)
              nack_q <= sda;
            else if (sclFall) begin
              bitCnt_q <= 4'h0;
              if (nack_q) begin
                sb_q <= SB_IDLE;             // host wants no more
              end else begin
                shift_q <= regView(ptr_q);
                ptr_q   <= ptr_q + 8'h01;
                sdaOe_b <= regView(ptr_q) >> 7 == 8'h01;
                sb_q    <= SB_TX;
              end
            end
          end
          default: sb_q <= SB_IDLE;
        endcase
      end
    end
  end

  // pins and supply controls, all registered
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sdaOut       <= 1'b0;
      serialPullup <= 1'b1;
      irqOut       <= 1'b0;
      irqOe_b      <= 1'b1;
      irqPullup    <= 1'b1;
      outRegulate  <= {NOUT{1'b0}};
      outHiZ       <= {NOUT{1'b1}};
      ovLoad       <= {NOUT{1'b0}};
      clampOn      <= 1'b0;
      energyMode   <= `PMHI_EM_ACTIVE;
      lowPower     <= 1'b1;
    end else begin
      sdaOut       <= 1'b0;                  // open drain only pulls low
      serialPullup <= serctlPull & ~serctlDirect;  // [RL4] [RL5]
      irqOut       <= 1'b0;                  // [RL6]
      irqPullup    <= 1'b1;                  // nothing can switch it off [RL6]
      // low while any set flag is unmasked [RL7] [RL8] [RL23]
      irqOe_b      <= ~(|(gStat_q & gMask_q) | |(vStat_q & vMask_q[NOUT-1:0]));
      // enabled outputs switch at once, others float [RL21] [RL22]
      outRegulate  <= run ? outEn_q[NOUT-1:0] : {NOUT{1'b0}};
      outHiZ       <= run ? ~outEn_q[NOUT-1:0] : {NOUT{1'b1}};
      // protection only outside shutdown; second output may opt out [RL15] [RL16]
      ovLoad       <= (run && emode_q != `PMHI_EM_SHUTDOWN)
                      ? ovS & ~({{(NOUT-1){1'b0}}, conv2_q[`PMHI_C_OVDIS]} << 1)
                      : {NOUT{1'b0}};
      clampOn      <= run & conv2_q[`PMHI_C_CLAMP];  // [RL17]
      energyMode   <= emode_q;
      lowPower     <= ~run & lockout;        // only power-on detection alive [RL12]
    end
  end

endmodule
`default_nettype wire

// file: tb/pmhi_top_properties.sv
// concurrent checks on the pins of the host port block
`timescale 1ns/1ps
`default_nettype none
module pmhi_top_properties #(
  parameter NOUT = 3 // number of supply outputs
) (
  input wire logic            clk, // system clock
  input wire logic            rst_b, // async reset, active low
  input wire logic            avs_read, // read request
  input wire logic            avs_write, // write request
  input wire logic            avs_waitrequest, // stall
  input wire logic            irqOut, // interrupt drive value
  input wire logic            irqPullup, // interrupt pin pull-up
  input wire logic            supplyOk, // main supply good
  input wire logic            lockoutTrip, // under-voltage lockout
  input wire logic [NOUT-1:0] outOverVolt, // output above level
  input wire logic [NOUT-1:0] outRegulate, // converter regulating
  input wire logic [NOUT-1:0] outHiZ, // output high-impedance
  input wire logic [NOUT-1:0] ovLoad, // internal load on
  input wire logic [1:0]      energyMode, // current energy mode
  input wire logic            lowPower // minimal-power state
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // stalled request
  sequence busReq;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  // answer for one cycle
  sequence busAns;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  bus_answer_a: assert property (busReq |=> busAns)
    else $error("late bus answer");
  irq_pullup_a: assert property (irqPullup && !irqOut)
    else $error("irq pin pull-up");
  hiz_disabled_a: assert property (outHiZ == ~outRegulate)
    else $error("output not hi-z");
  supply_off_a: assert property (!supplyOk [*6] |-> outRegulate == '0)
    else $error("on after supply loss");
  lockout_power_a: assert property (lockoutTrip [*6] |-> lowPower)
    else $error("no lockout state");
  load_first_a: assert property ($rose(outRegulate != '0) |-> $past(supplyOk, 8))
    else $error("early regulation");
  shutdown_noload_a: assert property ((energyMode == 2'h2) [*3] |-> ovLoad == '0)
    else $error("load in shutdown");
  ov_load_a: assert property ((outOverVolt[0] && outRegulate[0] && energyMode != 2'h2) [*6] |-> ovLoad[0])
    else $error("no ov load");
  ov_release_a: assert property ((outOverVolt == '0) [*6] |-> ovLoad == '0)
    else $error("load kept");
endmodule
bind pmhi_top pmhi_top_properties #(.NOUT(NOUT)) CHK (.clk, .rst_b, .avs_read, .avs_write, .avs_waitrequest,
  .irqOut, .irqPullup, .supplyOk, .lockoutTrip, .outOverVolt, .outRegulate, .outHiZ, .ovLoad, .energyMode,
  .lowPower);
`default_nettype wire

// file: tb/pmhi_host_model.sv
// host controller model driving the two-wire serial pins
`timescale 1ns/1ps
`default_nettype none
module pmhi_host_model (
  input  wire logic sdaOe_b, // device pulls data low when 0
  output wire logic sclLine, // serial clock wire level
  output wire logic sdaLine // serial data wire level
);
  logic sclRel;                                   // host releases clock
  logic sdaRel;                                   // host releases data
  // pull-ups make released lines high; wired-and with the device
  assign sclLine = sclRel;
  assign sdaLine = sdaRel & sdaOe_b;
  initial begin
    sclRel = 1'b1;
    sdaRel = 1'b1;
  end
  // one byte msb first, 80 ns a bit, then acknowledge
  task automatic sendByte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sdaRel = b[i];
      #20 sclRel = 1'b1;
      #40 sclRel = 1'b0;
      #20;
    end
    sdaRel = 1'b1;
    #20 sclRel = 1'b1;
    #20 ack = ~sdaLine;
    #20 sclRel = 1'b0;
    #20;
  endtask
  // start, address+write, pointer, data, stop
  task automatic writeReg(input logic [6:0] adr, input logic [7:0] ptr, input logic [7:0] val, output logic ack);
    logic a1, a2, a3;
    sdaRel = 1'b0;
    #40 sclRel = 1'b0;
    #20;
    sendByte({adr, 1'b0}, a1);
    sendByte(ptr, a2);
    sendByte(val, a3);
    sdaRel = 1'b0;
    #20 sclRel = 1'b1;
    #40 sdaRel = 1'b1;
    #80 ack = a1 & a2 & a3;
  endtask
  // static direct-mode levels; clock stands still otherwise
  task automatic setPins(input logic c, input logic d);
    sclRel = c;
    sdaRel = d;
  endtask
endmodule
`default_nettype wire

// file: tb/pmhi_top_bench.sv
// self-checking bench for the host port and status interrupt block
`timescale 1ns/1ps
`default_nettype none
module pmhi_top_bench;
  logic        clk, rst_b, avs_read, avs_write, avs_waitrequest;  // clock, reset, bus handshake
  logic [4:0]  avs_address; // byte address
  logic [31:0] avs_writedata, avs_readdata; // bus data
  wire logic   scl, sda; // serial wire levels
  logic        sdaOut, sdaOe_b, serialPullup, irqOut, irqOe_b, irqPullup; // pin controls
  logic        supplyOk, lockoutTrip, tempHot, clampOn, lowPower, ack;    // supply and status
  logic [2:0]  outLow, outOverVolt, outRegulate, outHiZ, ovLoad;  // per-output lines
  logic [1:0]  energyMode; // current mode
  logic [7:0]  rd; // last read value
  int          bad_count, n_checks; // counters
  // rows: write, address, data, expected read
  logic [21:0] rows [14] = '{{1'b0,5'h08,8'h00,8'h01}, {1'b0,5'h0C,8'h00,8'h00}, {1'b0,5'h10,8'h00,8'h01},
    {1'b0,5'h14,8'h00,8'h00}, {1'b0,5'h18,8'h00,8'h02}, {1'b1,5'h00,8'h01,8'h00}, {1'b0,5'h00,8'h00,8'h00},
    {1'b1,5'h1C,8'h01,8'h00}, {1'b0,5'h1C,8'h00,8'h01}, {1'b1,5'h1C,8'h03,8'h00}, {1'b0,5'h1C,8'h00,8'h01},
    {1'b1,5'h1C,8'h00,8'h00}, {1'b1,5'h18,8'h07,8'h00}, {1'b0,5'h18,8'h00,8'h07}};
  pmhi_top #(.NOUT(3), .OUTEN_INIT(8'h02)) DUT (.clk, .rst_b, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_readdata, .avs_waitrequest, .sclIn(scl), .sdaIn(sda), .sdaOut, .sdaOe_b, .serialPullup, .irqOut, .irqOe_b,
    .irqPullup, .supplyOk, .lockoutTrip, .tempHot, .outLow, .outOverVolt, .outRegulate, .outHiZ, .ovLoad, .clampOn,
    .energyMode, .lowPower);
  pmhi_host_model HOST (.sdaOe_b, .sclLine(scl), .sdaLine(sda));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    n_checks++;
    if (got !== exp) begin
      $display("CHECK FAILED at %0t: %s", $time, msg);
      bad_count++;
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // one bus transfer, held until waitrequest low
  task automatic busOp(input logic wr, input logic [4:0] a, input logic [7:0] d);
    int n = 0;
    {avs_address, avs_write, avs_read, avs_writedata} <= {a, wr, ~wr, 24'h000000, d};
    @(posedge clk);
    while (avs_waitrequest !== 1'b0 && n < 50) begin
      @(posedge clk);
      n++;
    end
    rd = avs_readdata[7:0];
    if (n >= 50) begin
      bad_count++;
      summarize();
    end
    {avs_write, avs_read} <= 2'b00;
    @(posedge clk);
  endtask
  // poll until the factory flag is up
  task automatic waitRun();
    int n = 0;
    rd = 8'h00;
    while (rd[0] !== 1'b1 && n < 60) begin
      busOp(1'b0, 5'h00, 8'h00);
      n++;
    end
    chk(rd[0], 1'b1, "factory flag");
  endtask
  initial begin
    {avs_read, avs_write, avs_address, avs_writedata} = '0;
    {tempHot, lockoutTrip, outLow, outOverVolt} = '0;
    supplyOk = 1'b1;
    rst_b = 1'b0;
    tick(6);
    rst_b <= 1'b1;
    waitRun();
    chk(irqOe_b, 1'b0, "factory irq");
    foreach (rows[i]) begin
      busOp(rows[i][21], rows[i][20:16], rows[i][15:8]);
      if (!rows[i][21]) chk(rd, rows[i][7:0], "register");
    end
    tick(4);
    chk({irqOe_b, irqPullup, serialPullup, outRegulate, outHiZ}, 9'h1F8, "idle");
    $display("register test done");
    // masked flags stay quiet
    tempHot <= 1'b1;
    outLow <= 3'h4;
    tick(6);
    chk(irqOe_b, 1'b1, "masked irq");
    tempHot <= 1'b0;
    outLow <= 3'h0;
    busOp(1'b1, 5'h08, 8'h03);
    busOp(1'b1, 5'h0C, 8'h04);
    busOp(1'b0, 5'h00, 8'h00);
    chk(rd, 8'h02, "temp flag");
    busOp(1'b0, 5'h04, 8'h00);
    chk({rd, irqOe_b}, 9'h008, "low flag");
    busOp(1'b1, 5'h00, 8'h02);
    tick(3);
    chk(irqOe_b, 1'b0, "early release");
    busOp(1'b1, 5'h04, 8'h04);
    tick(3);
    chk(irqOe_b, 1'b1, "no release");
    $display("flag test done");
    outOverVolt <= 3'h7;
    tick(8);
    chk(ovLoad, 3'h7, "ov load");
    busOp(1'b1, 5'h14, 8'h03);
    tick(4);
    chk({clampOn, ovLoad}, 4'hD, "second output");
    busOp(1'b1, 5'h1C, 8'h02);
    tick(4);
    chk({clampOn, ovLoad}, 4'h8, "shutdown");
    outOverVolt <= 3'h0;
    HOST.writeReg(7'h60, 8'h02, 8'h05, ack);
    busOp(1'b0, 5'h08, 8'h00);
    chk({ack, rd}, 9'h105, "serial write");
    HOST.writeReg(7'h61, 8'h02, 8'h00, ack);
    busOp(1'b0, 5'h08, 8'h00);
    chk({ack, rd}, 9'h005, "foreign address");
    $display("serial test done");
    busOp(1'b1, 5'h10, 8'h00);
    tick(3);
    chk(serialPullup, 1'b0, "pull-ups");
    busOp(1'b1, 5'h10, 8'h03);
    HOST.setPins(1'b1, 1'b0);
    tick(8);
    chk({serialPullup, energyMode}, 3'h1, "direct sleep");
    HOST.setPins(1'b0, 1'b0);
    tick(8);
    chk(energyMode, 2'h2, "direct shutdown");
    HOST.setPins(1'b1, 1'b1);
    tick(8);
    chk(energyMode, 2'h0, "direct active");
    busOp(1'b1, 5'h10, 8'h01);
    $display("direct mode test done");
    lockoutTrip <= 1'b1;
    tick(8);
    chk({lowPower, outRegulate, outHiZ}, 7'h47, "lockout");
    lockoutTrip <= 1'b0;
    supplyOk <= 1'b0;
    tick(8);
    chk({lowPower, outRegulate, outHiZ}, 7'h07, "supply loss");
    supplyOk <= 1'b1;
    waitRun();
    busOp(1'b0, 5'h08, 8'h00);
    chk({rd, irqOe_b}, 9'h002, "defaults");
    busOp(1'b1, 5'h08, 8'h03);
    rst_b <= 1'b0;
    tick(2);
    chk({irqOe_b, outHiZ}, 4'hF, "in reset");
    rst_b <= 1'b1;
    waitRun();
    chk({irqOe_b, outHiZ}, 4'h5, "restart");
    $display("supply and reset test done");
    summarize();
  end
endmodule
`default_nettype wire
